// ### sfc_pkg.sv
/*
   Shared constants for the serial flash command logic: opcodes, status
   bit positions, phase lengths, timing and the frame state encoding.
   Assumes a 250 MHz system clock and 8-bit array data.
*/
package sfc_pkg;

   // Opcodes handled by this block
   localparam logic [7:0] OP_WREN  = 8'h06;
   localparam logic [7:0] OP_WRDI  = 8'h04;
   localparam logic [7:0] OP_VWREN = 8'h50;
   localparam logic [7:0] OP_WSR1  = 8'h01;
   localparam logic [7:0] OP_WSR2  = 8'h31;
   localparam logic [7:0] OP_WSR3  = 8'h11;
   localparam logic [7:0] OP_RSR1  = 8'h05;
   localparam logic [7:0] OP_RSR2  = 8'h35;
   localparam logic [7:0] OP_RSR3  = 8'h15;
   localparam logic [7:0] OP_READ  = 8'h03;
   localparam logic [7:0] OP_FAST  = 8'h0b;
   localparam logic [7:0] OP_DOUT  = 8'h3b;
   localparam logic [7:0] OP_QOUT  = 8'h6b;
   localparam logic [7:0] OP_DIO   = 8'hbb;
   localparam logic [7:0] OP_CRMR  = 8'hff;

   // Status bit positions and masks
   localparam int          BIT_SRPL   = 7;
   localparam int          BIT_SRPH   = 8;
   localparam int          BIT_QE     = 9;
   localparam int          BIT_CMP    = 14;
   localparam logic [23:0] WSR_MASK   = 24'h607ffc;
   localparam logic [23:0] STATUS_RST = 24'h000000;
   localparam logic [1:0]  CONT_MODE  = 2'h2;

   // Phase lengths in serial clocks
   localparam logic [5:0] OPC_LAST    = 6'h07;
   localparam logic [5:0] ADDR_LAST_S = 6'h17;
   localparam logic [5:0] ADDR_LAST_D = 6'h0f;
   localparam logic [5:0] DUMMY_LAST  = 6'h07;
   localparam logic [5:0] WSR_SHORT   = 6'h08;
   localparam logic [5:0] WSR_LONG    = 6'h10;
   localparam logic [5:0] CNT_SAT     = 6'h3f;

   // Buffer shape
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 16;

   // Timing
   localparam int CLK_MHZ     = 250;
   localparam int WSR_TIME_US = 5000;
   localparam int WSR_CYCLES  = WSR_TIME_US * CLK_MHZ;

   // Frame states, one-hot
   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_OPC   = 7'h02,
      ST_ADDR  = 7'h04,
      ST_DUMMY = 7'h08,
      ST_DATA  = 7'h10,
      ST_SREAD = 7'h20,
      ST_WDATA = 7'h40
   } sfc_state_type;

   localparam sfc_state_type ST_SKIP = ST_IDLE;

endpackage : sfc_pkg

// ### sfc_top.sv
/*
   Serial flash command logic: status writes, write enables, status reads
   and the single, dual and quad read family with continuous dual mode.
   Assumes the link pins arrive asynchronously and are sampled by clk_i,
   and that an array port outside answers each byte request.
*/
// Notes on behaviour
// - Status write never changes bits 23, 20..15, 1 and 0.
// - Status write runs only if select rises after 8 or 16 bits.
// - Eight-bit WSR1 status write clears complement, quad enable and high protect.
// - Select rising on a valid status write starts the timed cycle.
// - Progress flag is 1 during the cycle, 0 after; status stays readable.
// - Write enable latch clears when the timed cycle completes.
// - Write enable instruction sets the write enable latch.
// - Status write updates block protect and status protect bits.
// - Hardware protected mode refuses every status write.
// - Volatile enable leaves the latch; next status write skips the timed cycle.
// - Normal read takes 24 address bits, shifts data out on falling edges.
// - Address advances after every byte until select rises.
// - Normal read during a running cycle is ignored.
// - Fast read takes address plus one dummy byte before data.
// - Dual output read drives two bits per clock.
// - Quad output read drives four bits per clock.
// - Dual I/O read takes address and mode two bits per clock.
// - Mode bits 5:4 equal to 10 make the next frame opcode-free.
// - Mode reset instruction is decoded only with continuous mode off; mode bits 5:4 other than 10 clear the stored mode.
// - Two-bit output puts even bits on line 0, odd on line 1.
`timescale 1ns/10ps

module sfc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             flush_i,
   // Fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   // Flags straight from the fill count
   assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;
   assign out_data_o  = mem_q[rd_q];

   // Storage, no reset needed
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   // Pointers wrap naturally, depth is a power of two
   always_ff @(posedge clk_i) begin
      if (rst_i || flush_i) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : sfc_fifo

module sfc_top
   import sfc_pkg::*;
#(
   parameter int unsigned TW_CYCLES = WSR_CYCLES
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Serial link
   input  wire logic        sclk_i,
   input  wire logic        cs_n_i,
   input  wire logic [3:0]  io_i,
   output logic      [3:0]  io_o,
   output logic      [3:0]  io_oe_o,
   input  wire logic        wp_n_i,
   // Array side
   input  wire logic        array_busy_i,
   output logic             mem_req_o,
   input  wire logic        mem_ready_i,
   output logic      [23:0] mem_addr_o,
   input  wire logic        mem_valid_i,
   input  wire logic [7:0]  mem_data_i,
   // Status view
   output logic      [23:0] status_o,
   output logic             cont_mode_o
);
   logic          sclk_m, sclk_s, sclk_d;
   logic          cs_m, cs_s, cs_d;
   logic [3:0]    io_m, io_s;
   logic          wp_m, wp_s;
   logic          rise, fall, frame_start, frame_end;
   sfc_state_type state_q;
   logic [5:0]    cnt_q;
   logic [31:0]   sh_q, sh_next;
   logic [7:0]    opc_q, op;
   logic          dual_q, dummy_q;
   logic [2:0]    lanes_q;
   logic          addr_last;
   logic [23:0]   addr_cap;
   logic [7:0]    mode_cap;
   logic          cont_q, vol_q, wel_q, wip_q;
   logic [23:0]   st_q, new_q, cand, merged;
   logic [31:0]   tw_cnt_q;
   logic          hw_prot, wsr_ok, rd_ok, wsr_valid;
   logic          fetch_on_q, pend_q, drop_q;
   logic [23:0]   fetch_addr_q;
   logic          fifo_in_ready, fifo_out_valid, pop;
   logic [7:0]    fifo_dout;
   logic [2:0]    obit_q, obit_last;
   logic [7:0]    out_sh_q, cur, stat_byte;
   logic [3:0]    io_q, oe_q;

   // Two-flop synchronisers; the third stage only feeds edge detection
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sclk_m <= 1'b0;
         sclk_s <= 1'b0;
         sclk_d <= 1'b0;
         cs_m   <= 1'b1;
         cs_s   <= 1'b1;
         cs_d   <= 1'b1;
         io_m   <= 4'h0;
         io_s   <= 4'h0;
         wp_m   <= 1'b1;
         wp_s   <= 1'b1;
      end else begin
         sclk_m <= sclk_i;
         sclk_s <= sclk_m;
         sclk_d <= sclk_s;
         cs_m   <= cs_n_i;
         cs_s   <= cs_m;
         cs_d   <= cs_s;
         io_m   <= io_i;
         io_s   <= io_m;
         wp_m   <= wp_n_i;
         wp_s   <= wp_m;
      end
   end

   // Link events
   assign rise        = sclk_s & ~sclk_d & ~cs_s;
   assign fall        = ~sclk_s & sclk_d & ~cs_s;
   assign frame_start = ~cs_s & cs_d;
   assign frame_end   = cs_s & ~cs_d;

   // Input shifting, MSB first; dual I/O takes two bits per edge
   assign sh_next   = dual_q ? {sh_q[29:0], io_s[1], io_s[0]}
                             : {sh_q[30:0], io_s[0]};
   assign op        = sh_next[7:0];
   assign addr_cap  = dual_q ? sh_next[31:8] : sh_next[23:0];
   assign mode_cap  = sh_next[7:0];
   assign addr_last = rise && (state_q == ST_ADDR) &&
                      (cnt_q == (dual_q ? ADDR_LAST_D : ADDR_LAST_S));

   // Protection and acceptance checks
   assign hw_prot = st_q[BIT_SRPH] | (st_q[BIT_SRPL] & ~wp_s);
   assign wsr_ok  = (wel_q | vol_q) & ~hw_prot & ~wip_q;
   assign rd_ok   = ~wip_q & ~array_busy_i;

   // Frame sequencer, advanced on sampled rising serial clock
   always_ff @(posedge clk_i) begin
      if (rst_i || cs_s) begin
         state_q <= ST_IDLE;
         cnt_q   <= 6'h00;
         if (rst_i) begin
            sh_q    <= 32'h0;
            opc_q   <= 8'h00;
            dual_q  <= 1'b0;
            dummy_q <= 1'b0;
            lanes_q <= 3'h1;
         end
      end else if (frame_start) begin
         cnt_q   <= 6'h00;
         dual_q  <= cont_q;
         dummy_q <= 1'b0;
         lanes_q <= cont_q ? 3'h2 : 3'h1;
         opc_q   <= cont_q ? OP_DIO : 8'h00;
         state_q <= cont_q ? ST_ADDR : ST_OPC;
      end else if (rise) begin
         sh_q <= sh_next;
         cnt_q <= (cnt_q == CNT_SAT) ? cnt_q : cnt_q + 6'h01;
         case (state_q)
            ST_OPC: begin
               if (cnt_q == OPC_LAST) begin
                  opc_q <= op;
                  cnt_q <= 6'h00;
                  case (op)
                     OP_READ: begin
                        state_q <= rd_ok ? ST_ADDR : ST_SKIP;
                     end
                     OP_FAST: begin
                        state_q <= ST_ADDR;
                        dummy_q <= 1'b1;
                     end
                     OP_DOUT: begin
                        state_q <= ST_ADDR;
                        dummy_q <= 1'b1;
                        lanes_q <= 3'h2;
                     end
                     OP_QOUT: begin
                        state_q <= ST_ADDR;
                        dummy_q <= 1'b1;
                        lanes_q <= 3'h4;
                     end
                     OP_DIO: begin
                        state_q <= ST_ADDR;
                        dual_q  <= 1'b1;
                        lanes_q <= 3'h2;
                     end
                     OP_RSR1, OP_RSR2, OP_RSR3: begin
                        state_q <= ST_SREAD;
                     end
                     OP_WSR1, OP_WSR2, OP_WSR3: begin
                        state_q <= wsr_ok ? ST_WDATA : ST_SKIP;
                     end
                     default: begin
                        state_q <= ST_SKIP;
                     end
                  endcase
               end
            end
            ST_ADDR: begin
               if (addr_last) begin
                  cnt_q   <= 6'h00;
                  state_q <= dummy_q ? ST_DUMMY : ST_DATA;
               end
            end
            ST_DUMMY: begin
               if (cnt_q == DUMMY_LAST) begin
                  state_q <= ST_DATA;
               end
            end
            default: begin
               state_q <= state_q;
            end
         endcase
      end
   end

   // Continuous dual mode memory
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cont_q <= 1'b0;
      end else if (addr_last && dual_q) begin
         cont_q <= (mode_cap[5:4] == CONT_MODE);
      end else if (frame_end && state_q == ST_SKIP && opc_q == OP_CRMR) begin
         cont_q <= 1'b0;
      end
   end

   // Status write candidate; first WSR1 data byte lands in bits 7:0, WSR2 and WSR3 bytes in 15:8 and 23:16
   always_comb begin
      cand = st_q;
      case (opc_q)
         OP_WSR1: begin
            if (cnt_q == WSR_SHORT) begin
               cand[7:0]      = sh_q[7:0];
               cand[BIT_CMP]  = 1'b0;
               cand[BIT_QE]   = 1'b0;
               cand[BIT_SRPH] = 1'b0;
            end else begin
               cand[15:0] = {sh_q[7:0], sh_q[15:8]};
            end
         end
         OP_WSR2: begin
            cand[15:8] = sh_q[7:0];
         end
         OP_WSR3: begin
            cand[23:16] = sh_q[7:0];
         end
         default: begin
            cand = st_q;
         end
      endcase
      merged = (cand & WSR_MASK) | (st_q & ~WSR_MASK);
   end

   // Only exact byte boundaries execute
   assign wsr_valid = frame_end && (state_q == ST_WDATA) &&
                      ((cnt_q == WSR_SHORT) ||
                       (cnt_q == WSR_LONG && opc_q == OP_WSR1));

   // Status bits and the self-timed write cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q     <= STATUS_RST;
         new_q    <= STATUS_RST;
         wip_q    <= 1'b0;
         tw_cnt_q <= 32'h0;
      end else if (wip_q) begin
         if (tw_cnt_q == 32'h0) begin
            st_q  <= new_q;
            wip_q <= 1'b0;
         end else begin
            tw_cnt_q <= tw_cnt_q - 32'h1;
         end
      end else if (wsr_valid) begin
         if (vol_q) begin
            st_q <= merged;
         end else begin
            new_q    <= merged;
            wip_q    <= 1'b1;
            tw_cnt_q <= 32'(TW_CYCLES - 1);
         end
      end
   end

   // Write enable latch; a set in the completion cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wel_q <= 1'b0;
      end else if (frame_end && state_q == ST_SKIP && cnt_q == 6'h00 &&
                   opc_q == OP_WREN) begin
         wel_q <= 1'b1;
      end else if (wip_q && tw_cnt_q == 32'h0) begin
         wel_q <= 1'b0;
      end else if (frame_end && state_q == ST_SKIP && cnt_q == 6'h00 &&
                   opc_q == OP_WRDI) begin
         wel_q <= 1'b0;
      end
   end

   // Volatile enable lasts for the next frame only, latch untouched
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vol_q <= 1'b0;
      end else if (frame_end) begin
         vol_q <= (state_q == ST_SKIP) && (cnt_q == 6'h00) &&
                  (opc_q == OP_VWREN);
      end
   end

   // Array fetch: one request outstanding, late answers dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fetch_on_q   <= 1'b0;
         fetch_addr_q <= 24'h0;
         pend_q       <= 1'b0;
         drop_q       <= 1'b0;
      end else begin
         if (addr_last) begin
            fetch_on_q   <= 1'b1;
            fetch_addr_q <= addr_cap;
         end else if (cs_s) begin
            fetch_on_q <= 1'b0;
         end
         if (mem_req_o && mem_ready_i) begin
            pend_q       <= 1'b1;
            fetch_addr_q <= fetch_addr_q + 24'h1;
         end else if (mem_valid_i) begin
            pend_q <= 1'b0;
         end
         if (mem_valid_i) begin
            drop_q <= 1'b0;
         end else if (frame_end && pend_q) begin
            drop_q <= 1'b1;
         end
      end
   end

   assign mem_req_o  = fetch_on_q & ~cs_s & ~pend_q & ~drop_q & fifo_in_ready;
   assign mem_addr_o = fetch_addr_q;

   // Prefetch buffer between array and shifter, flushed per frame
   sfc_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .flush_i     (frame_end),
      .in_valid_i  (mem_valid_i & pend_q & ~drop_q),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (mem_data_i),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (pop),
      .out_data_o  (fifo_dout)
   );

   // Output byte selection
   always_comb begin
      case (opc_q)
         OP_RSR2: stat_byte = status_o[15:8];
         OP_RSR3: stat_byte = status_o[23:16];
         default: stat_byte = status_o[7:0];
      endcase
      if (obit_q != 3'h0) begin
         cur = out_sh_q;
      end else if (state_q == ST_DATA) begin
         cur = fifo_out_valid ? fifo_dout : 8'h00;
      end else begin
         cur = stat_byte;
      end
   end

   assign obit_last = (lanes_q == 3'h4) ? 3'h1 : (lanes_q == 3'h2) ? 3'h3 : 3'h7;
   assign pop       = fall && (state_q == ST_DATA) && (obit_q == 3'h0);

   // Output shifter on sampled falling edges; released when deselected
   always_ff @(posedge clk_i) begin
      if (rst_i || cs_s) begin
         obit_q   <= 3'h0;
         out_sh_q <= 8'h00;
         io_q     <= 4'h0;
         oe_q     <= 4'h0;
      end else if (fall && (state_q == ST_DATA || state_q == ST_SREAD)) begin
         obit_q <= (obit_q == obit_last) ? 3'h0 : obit_q + 3'h1;
         case (lanes_q)
            3'h4: begin
               io_q     <= cur[7:4];
               oe_q     <= 4'hf;
               out_sh_q <= {cur[3:0], 4'h0};
            end
            3'h2: begin
               io_q     <= {2'h0, cur[7], cur[6]};
               oe_q     <= 4'h3;
               out_sh_q <= {cur[5:0], 2'h0};
            end
            default: begin
               io_q     <= {2'h0, cur[7], 1'b0};
               oe_q     <= 4'h2;
               out_sh_q <= {cur[6:0], 1'b0};
            end
         endcase
      end
   end

   // Outputs
   assign io_o        = io_q;
   assign io_oe_o     = oe_q;
   assign status_o    = {st_q[23:2], wel_q, wip_q};
   assign cont_mode_o = cont_q;

endmodule : sfc_top

// ### sfc_top_asserts.sv
/*
   Port checker for sfc_top: link release, output enables, status timing, array handshake.
   Assumes it is bound to sfc_top and sees only its ports.
*/
`timescale 1ns/10ps
module sfc_top_asserts
   import sfc_pkg::*;
#(
   parameter int unsigned TW_CYCLES = 20
) (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // Link and array side
   input wire logic        cs_n_i,
   input wire logic        wp_n_i,
   input wire logic [3:0]  io_oe_o,
   input wire logic        array_busy_i,
   input wire logic        mem_req_o,
   input wire logic        mem_ready_i,
   input wire logic [23:0] mem_addr_o,
   // Status view
   input wire logic [23:0] status_o,
   input wire logic        cont_mode_o
);
   logic [31:0] wip_cnt_q;
   logic        busy_frame_q;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Cycles spent with the progress flag up
   always_ff @(posedge clk_i) begin
      if (rst_i || !status_o[0]) wip_cnt_q <= 32'h0;
      else wip_cnt_q <= wip_cnt_q + 32'h1;
   end

   // Frame opened while busy; dropped with busy so it never over-claims
   always_ff @(posedge clk_i) begin
      if (rst_i || cs_n_i || !array_busy_i) busy_frame_q <= 1'b0;
      else if ($fell(cs_n_i)) busy_frame_q <= 1'b1;
   end

   AST_OE_IDLE: assert property (cs_n_i [*5] |-> io_oe_o == 4'h0)
      else $error("data lines driven while deselected");
   AST_OE_SHAPE: assert property (io_oe_o inside {4'h0, 4'h2, 4'h3, 4'hf})
      else $error("illegal output enable pattern");
   AST_WIP_LEN: assert property ($fell(status_o[0]) |->
      wip_cnt_q >= TW_CYCLES - 1 && wip_cnt_q <= TW_CYCLES + 1)
      else $error("cycle length wrong");
   AST_WEL_CLR: assert property ($fell(status_o[0]) |-> !status_o[1])
      else $error("latch kept after cycle");
   AST_WIP_CAUSE: assert property ($rose(status_o[0]) |-> $past(status_o[1]))
      else $error("cycle without latch");
   AST_FIXED_BITS: assert property ((status_o & ~(WSR_MASK | 24'h000003)) == 24'h0)
      else $error("fixed status bit changed");
   AST_HW_LOCK: assert property ($past(status_o[8] || (status_o[7] && !wp_n_i)) |->
      $stable(status_o[23:2]))
      else $error("status changed while locked");
   AST_MEM_HOLD: assert property (mem_req_o && !mem_ready_i |=>
      mem_req_o && $stable(mem_addr_o))
      else $error("array request dropped or moved");
   AST_BUSY_READ: assert property (busy_frame_q |-> !mem_req_o)
      else $error("read served while array busy");

   // Main scenarios reached
   COV_WIP_DONE: cover property ($fell(status_o[0]));
   COV_CONT: cover property ($rose(cont_mode_o));
   COV_QUAD: cover property (io_oe_o == 4'hf);
endmodule : sfc_top_asserts

// ### sfc_array_model.sv
/*
   Behavioural array behind the read path: answers byte requests.
   Assumes one outstanding request and a same-cycle ready handshake.
*/
`timescale 1ns/10ps
module sfc_array_model (
   // Clock, reset and pacing
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        slow_i,
   // Request side
   input  wire logic        mem_req_i,
   output logic             mem_ready_o,
   input  wire logic [23:0] mem_addr_i,
   // Answer side
   output logic             mem_valid_o,
   output logic      [7:0]  mem_data_o
);
   logic [2:0]  lat_q;
   logic [23:0] addr_q;
   logic        tick_q;
   logic [7:0]  byte_w;

   // Slow mode accepts every other cycle only, to stall the fill
   always_ff @(posedge clk_i) tick_q <= rst_i ? 1'b0 : ~tick_q;
   assign mem_ready_o = ~slow_i | tick_q;

   // Fixed three-cycle answer, inside the eight allowed
   always_ff @(posedge clk_i) begin
      if (rst_i) lat_q <= 3'h0;
      else lat_q <= {lat_q[1:0], mem_req_i & mem_ready_o};
   end

   // Accepted address kept for the answer
   always_ff @(posedge clk_i) begin
      if (rst_i) addr_q <= 24'h0;
      else if (mem_req_i && mem_ready_o) addr_q <= mem_addr_i;
   end

   // Pattern folds the address; inverted between answers so stale data shows
   assign byte_w      = addr_q[7:0] ^ addr_q[23:16] ^ 8'h5a;
   assign mem_valid_o = lat_q[2];
   assign mem_data_o  = lat_q[2] ? byte_w : ~byte_w;
endmodule : sfc_array_model

// ### tb_sfc_top.sv
/*
   Bench for sfc_top: host frames driven on the link, array model behind.
   Assumes a 250 MHz clock and a 160 ns link clock only inside frames.
*/
`timescale 1ns/10ps
module tb_sfc_top
   import sfc_pkg::*;
   ;
   typedef struct packed {
      logic [7:0]  op;
      logic [23:0] addr;
      logic [2:0]  aw;
      logic [2:0]  ow;
      logic [7:0]  mode;
      logic [4:0]  nb;
      logic        slow;
   } sfc_row_type;

   logic        clk_i, rst_i, sclk_i, cs_n_i, wp_n_i, array_busy_i, slow_q;
   logic        mem_req_o, mem_ready_i, mem_valid_i, cont_mode_o;
   logic [3:0]  io_i, io_o, io_oe_o, oe_seen;
   logic [7:0]  mem_data_i, b;
   logic [23:0] mem_addr_o, status_o;
   int          fails, n_compared;
   sfc_row_type rows [6], r;

   sfc_top #(.TW_CYCLES(4000)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .io_i(io_i),
      .io_o(io_o), .io_oe_o(io_oe_o), .wp_n_i(wp_n_i), .array_busy_i(array_busy_i),
      .mem_req_o(mem_req_o), .mem_ready_i(mem_ready_i), .mem_addr_o(mem_addr_o),
      .mem_valid_i(mem_valid_i), .mem_data_i(mem_data_i), .status_o(status_o),
      .cont_mode_o(cont_mode_o));
   sfc_array_model mdl_u (
      .clk_i(clk_i), .rst_i(rst_i), .slow_i(slow_q), .mem_req_i(mem_req_o),
      .mem_ready_o(mem_ready_i), .mem_addr_i(mem_addr_o), .mem_valid_o(mem_valid_i),
      .mem_data_o(mem_data_i));

   // 250 MHz system clock
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   function automatic logic [7:0] expb(input logic [23:0] a);
      return a[7:0] ^ a[23:16] ^ 8'h5a;
   endfunction : expb

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test

   // One link clock: fall, sample late in the low half, then rise
   task automatic unit(input logic [3:0] din, output logic [3:0] dout);
      io_i <= din;
      sclk_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      dout = io_o;
      oe_seen = oe_seen | io_oe_o;
      sclk_i <= 1'b1;
      repeat (20) @(posedge clk_i);
   endtask : unit

   task automatic send(input logic [7:0] v, input int w);
      logic [3:0] d;
      for (int i = 0; i < 8 / w; i++) begin
         if (w == 1) unit({3'h0, v[7-i]}, d);
         else unit({2'h0, v[7-2*i], v[6-2*i]}, d);
      end
   endtask : send

   // Lines no longer driven by the host toggle every clock
   task automatic recv(input int w, output logic [7:0] v);
      logic [3:0] d;
      for (int i = 0; i < 8 / w; i++) begin
         unit(~io_i, d);
         v = (w == 1) ? {v[6:0], d[1]} : (w == 2) ? {v[5:0], d[1:0]} : {v[3:0], d};
      end
   endtask : recv

   task automatic cs_low;
      repeat (6) @(posedge clk_i);
      cs_n_i <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask : cs_low

   // Clock is parked low only after select has risen
   task automatic cs_high;
      cs_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      sclk_i <= 1'b0;
      io_i <= ~io_i;
      repeat (6) @(posedge clk_i);
   endtask : cs_high

   task automatic cmd(input logic [7:0] op);
      cs_low;
      send(op, 1);
      cs_high;
   endtask : cmd

   task automatic wsr(input logic [7:0] op, input logic [15:0] d, input int nb);
      logic [3:0] x;
      cs_low;
      send(op, 1);
      for (int i = 0; i < nb; i++) unit({3'h0, d[15-i]}, x);
      cs_high;
   endtask : wsr

   task automatic do_read(input sfc_row_type rr, input logic cont);
      logic [7:0] v;
      cs_low;
      if (!cont) send(rr.op, 1);
      for (int i = 2; i >= 0; i--) send(rr.addr[8*i +: 8], rr.aw);
      if (rr.op != OP_READ) send(rr.mode, rr.aw);
      for (int i = 0; i < rr.nb; i++) begin
         recv(rr.ow, v);
         check(v, expb(rr.addr + 24'(i)));
      end
      cs_high;
   endtask : do_read

   task automatic rej_read;
      oe_seen = 4'h0;
      cs_low;
      send(OP_READ, 1);
      for (int i = 0; i < 3; i++) send(8'h10, 1);
      recv(1, b);
      cs_high;
      check(oe_seen, 4'h0);
   endtask : rej_read

   task automatic wait_wip;
      int k = 0;
      while (status_o[0] !== 1'b0 && k < 10000) begin
         @(posedge clk_i);
         k++;
      end
      if (k == 10000) begin
         fails++;
         finish_test;
      end
   endtask : wait_wip

   // Hang guard
   initial begin
      repeat (90000) @(posedge clk_i);
      fails++;
      finish_test;
   end

   // Main sequence
   initial begin
      rst_i = 1'b1;
      cs_n_i = 1'b1;
      sclk_i = 1'b0;
      io_i = 4'h0;
      wp_n_i = 1'b1;
      array_busy_i = 1'b0;
      slow_q = 1'b0;
      fails = 0;
      n_compared = 0;
      rows = '{'{OP_READ, 24'h0000fe, 3'h1, 3'h1, 8'h00, 5'h03, 1'b0},
               '{OP_FAST, 24'h123456, 3'h1, 3'h1, 8'h00, 5'h02, 1'b0},
               '{OP_DOUT, 24'habcdef, 3'h1, 3'h2, 8'h00, 5'h03, 1'b0},
               '{OP_QOUT, 24'h00fffe, 3'h1, 3'h4, 8'h00, 5'h03, 1'b0},
               '{OP_DIO, 24'h7654ff, 3'h2, 3'h2, 8'h00, 5'h03, 1'b0},
               '{OP_READ, 24'hfffff8, 3'h1, 3'h1, 8'h00, 5'h14, 1'b1}};
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check(status_o, 24'h0);
      check(cont_mode_o, 1'b0);
      check(io_oe_o, 4'h0);
      $display("test reset done");
      foreach (rows[i]) begin
         slow_q <= rows[i].slow;
         do_read(rows[i], 1'b0);
         $display("test read row %0d done", i);
      end
      slow_q <= 1'b0;
      cmd(OP_WREN);
      check(status_o[1], 1'b1);
      wsr(OP_WSR1, 16'h7fc2, 16);
      check(status_o[1:0], 2'h3);
      cs_low;
      send(OP_RSR1, 1);
      recv(1, b);
      cs_high;
      check(b[1:0], 2'h3);
      rej_read;
      wait_wip;
      check(status_o, 24'h00427c);
      cmd(OP_WREN);
      wsr(OP_WSR1, 16'h0400, 8);
      wait_wip;
      check(status_o, 24'h000004);
      cmd(OP_WREN);
      wsr(OP_WSR1, 16'hfff0, 12);
      check(status_o, 24'h000006);
      cmd(OP_WRDI);
      wsr(OP_WSR1, 16'h1000, 8);
      check(status_o, 24'h000004);
      cmd(OP_VWREN);
      wsr(OP_WSR1, 16'h8800, 8);
      check(status_o, 24'h000088);
      wp_n_i <= 1'b0;
      cmd(OP_VWREN);
      wsr(OP_WSR1, 16'h0000, 8);
      check(status_o, 24'h000088);
      wp_n_i <= 1'b1;
      cmd(OP_VWREN);
      wsr(OP_WSR1, 16'h0000, 8);
      check(status_o, 24'h000000);
      $display("test status write done");
      array_busy_i <= 1'b1;
      rej_read;
      array_busy_i <= 1'b0;
      $display("test busy read done");
      r = rows[4];
      r.mode = 8'h20;
      do_read(r, 1'b0);
      check(cont_mode_o, 1'b1);
      r.mode = 8'h00;
      do_read(r, 1'b1);
      check(cont_mode_o, 1'b0);
      $display("test continuous mode done");
      finish_test;
   end
endmodule : tb_sfc_top

bind sfc_top sfc_top_asserts #(.TW_CYCLES(TW_CYCLES)) chk_u (
   .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .wp_n_i(wp_n_i), .io_oe_o(io_oe_o),
   .array_busy_i(array_busy_i), .mem_req_o(mem_req_o), .mem_ready_i(mem_ready_i),
   .mem_addr_o(mem_addr_o), .status_o(status_o), .cont_mode_o(cont_mode_o));
